// ---- hdl/ahb_slave.sv ----
`timescale 1ns/1ps
module ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] rdata,
  output logic             wr_en,
  output logic             rd_en,
  output logic [7:0]       addr,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  logic       wpend_r;
  logic       wpend_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic       take;

  // ==========================================================================
  // Address phase capture; write done in data phase
  always_comb begin
    take      = hsel & hready & htrans[1];
    wpend_nxt = take & hwrite;
    addr_nxt  = take ? haddr[7:0] : addr_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_r <= 1'b0;
      addr_r  <= 8'h00;
    end else begin
      wpend_r <= wpend_nxt;
      addr_r  <= addr_nxt;
    end
  end

  assign wr_en     = wpend_r;
  assign rd_en     = take & ~hwrite;
  assign addr      = wpend_r ? addr_r : haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rdata;
    end
  end

  logic unused_hsize;
  assign unused_hsize = ^hsize;
endmodule // ahb_slave

// ---- hdl/ccp_pkg.sv ----
package ccp_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] off_ctrl   = 8'h00;
  localparam logic [7:0] off_cmp    = 8'h04;
  localparam logic [7:0] off_tmr    = 8'h08;
  localparam logic [7:0] off_status = 8'h0C;
  localparam logic [7:0] off_mask   = 8'h10;
  localparam logic [7:0] off_pin    = 8'h14;

  // ==========================================================================
  // Control field positions
  localparam int ctrl_mode_lsb     = 0;
  localparam int ctrl_gate_en_bit  = 4;
  localparam int ctrl_gate_pol_bit = 5;
  localparam int ctrl_clk_sel_bit  = 6;
  localparam int ctrl_adc_en_bit   = 7;
  localparam int ctrl_tmr_on_bit   = 8;

  // ==========================================================================
  // Reset values
  localparam logic [8:0]  ctrl_reset  = 9'h000;
  localparam logic [15:0] cmp_reset   = 16'h0000;
  localparam logic [15:0] tmr_reset   = 16'h0000;
  localparam logic [1:0]  mask_reset  = 2'h0;

  // ==========================================================================
  // Status bit positions
  localparam int st_match_bit = 0;
  localparam int st_ovf_bit   = 1;

  // ==========================================================================
  // Timing
  localparam int pulse_cycles = 1;

  // ==========================================================================
  // Modes
  typedef enum logic [3:0] {
    mode_off        = 4'b0000,
    mode_tgl_clr    = 4'b0001,
    mode_tgl        = 4'b0010,
    mode_cap_fall   = 4'b0100,
    mode_cap_rise   = 4'b0101,
    mode_cap_rise4  = 4'b0110,
    mode_cap_rise16 = 4'b0111,
    mode_set        = 4'b1000,
    mode_clr        = 4'b1001,
    mode_pulse      = 4'b1010,
    mode_pulse_clr  = 4'b1011
  } mode_t;

  typedef struct packed {
    logic       tmr_on;
    logic       adc_en;
    logic       clk_sel;
    logic       gate_pol;
    logic       gate_en;
    logic [3:0] mode;
  } ctrl_t;

endpackage

// ---- hdl/ccp_timer.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Gated timer counts only while gate level equals polarity setting.
// - Gate applies only when gate enable set; otherwise counts freely.
// - Capture uses the timer, clocked by instruction clock or external clock.
// - On instruction clock the timer holds in sleep, resumes after wake.
// - Capture works in sleep if the selected clock keeps running.
// - Compare mode checks compare pair against timer count each timer tick.
// - Match drives pin per mode: toggle, set, clear, pulse variants.
// - Every match sets flag with pin action and optionally triggers ADC.
// - Modes 0001 and 1011 clear the timer count on match.
module ccp_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sleep,
  input  wire logic        ext_clk_pin,
  input  wire logic        gate_signal,
  input  wire logic        capture_pin,
  output logic             unit_output_pin,
  output logic             adc_trigger,
  output logic             irq
);
  // ==========================================================================
  // Bus slave
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr;
  logic [31:0] rdata;
  logic        hrdata_w;

  ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rdata     (rdata),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .addr      (addr),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  // ==========================================================================
  // Pin synchronisers
  logic ext_lvl;
  logic ext_rise;
  logic gate_lvl;
  logic cap_lvl;
  logic cap_rise;
  logic cap_fall;

  pin_sync u_ext (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (ext_clk_pin),
    .level   (ext_lvl),
    .rise    (ext_rise),
    .fall    ()
  );

  pin_sync u_gate (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (gate_signal),
    .level   (gate_lvl),
    .rise    (),
    .fall    ()
  );

  pin_sync u_cap (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (capture_pin),
    .level   (cap_lvl),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  // ==========================================================================
  // State
  ccp_pkg::ctrl_t ctrl_r, ctrl_nxt;
  logic [15:0] cmp_r, cmp_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [1:0]  st_r, st_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic        pin_r, pin_nxt;
  logic        adc_r, adc_nxt;
  logic        irq_r, irq_nxt;
  logic [3:0]  pre_r, pre_nxt;

  logic        tick;
  logic        gate_ok;
  logic        is_cmp;
  logic        is_cap;
  logic        match;
  logic        cap_evt;
  logic        cap_edge;
  logic [1:0]  st_set;
  logic [15:0] tmr_inc;

  function automatic logic mode_is_compare(input logic [3:0] m);
    return (m == ccp_pkg::mode_tgl_clr) || (m == ccp_pkg::mode_tgl) || (m[3:2] == 2'b10);
  endfunction

  function automatic logic mode_is_capture(input logic [3:0] m);
    return (m[3:2] == 2'b01);
  endfunction

  always_comb begin
    is_cmp   = mode_is_compare(ctrl_r.mode);
    is_cap   = mode_is_capture(ctrl_r.mode);
    // Instruction clock stops in sleep; external keeps running
    tick     = ctrl_r.tmr_on & (ctrl_r.clk_sel ? ext_rise : ~sleep);
    gate_ok  = ~ctrl_r.gate_en | (gate_lvl == ctrl_r.gate_pol);
    match    = is_cmp & tick & (cmp_r == tmr_r);
    cap_edge = (ctrl_r.mode == ccp_pkg::mode_cap_fall) ? cap_fall : cap_rise;
    cap_evt  = 1'b0;
    unique case (ctrl_r.mode)
      ccp_pkg::mode_cap_fall,
      ccp_pkg::mode_cap_rise:   cap_evt = cap_edge;
      ccp_pkg::mode_cap_rise4:  cap_evt = cap_rise & (pre_r[1:0] == 2'b11);
      ccp_pkg::mode_cap_rise16: cap_evt = cap_rise & (pre_r == 4'hF);
      default:                  cap_evt = 1'b0;
    endcase
    cap_evt  = cap_evt & is_cap;
    tmr_inc  = tmr_r + 16'h0001;

    ctrl_nxt = ctrl_r;
    cmp_nxt  = cmp_r;
    tmr_nxt  = tmr_r;
    mask_nxt = mask_r;
    pin_nxt  = pin_r;
    adc_nxt  = 1'b0;
    pre_nxt  = (is_cap & cap_rise) ? pre_r + 4'h1 : pre_r;
    st_set   = 2'b00;

    if (tick && gate_ok) begin
      tmr_nxt = tmr_inc;
      if (tmr_r == 16'hFFFF) begin
        st_set[ccp_pkg::st_ovf_bit] = 1'b1;
      end
    end
    if (!is_cmp && !is_cap) begin
      pin_nxt = 1'b0;
    end
    if (ctrl_r.mode == ccp_pkg::mode_pulse || ctrl_r.mode == ccp_pkg::mode_pulse_clr) begin
      pin_nxt = 1'b0;
    end
    if (match) begin
      st_set[ccp_pkg::st_match_bit] = 1'b1;
      adc_nxt = ctrl_r.adc_en;
      unique case (ctrl_r.mode)
        ccp_pkg::mode_tgl_clr,
        ccp_pkg::mode_tgl:       pin_nxt = ~pin_r;
        ccp_pkg::mode_set:       pin_nxt = 1'b1;
        ccp_pkg::mode_clr:       pin_nxt = 1'b0;
        default:                 pin_nxt = 1'b1;
      endcase
      if (ctrl_r.mode == ccp_pkg::mode_tgl_clr || ctrl_r.mode == ccp_pkg::mode_pulse_clr) begin
        tmr_nxt = 16'h0000;
      end
    end
    if (cap_evt) begin
      cmp_nxt = tmr_r;
      st_set[ccp_pkg::st_match_bit] = 1'b1;
    end

    // Software writes; hardware capture wins over a compare write
    if (wr_en) begin
      unique case (addr)
        ccp_pkg::off_ctrl: begin
          ctrl_nxt = ccp_pkg::ctrl_t'(hwdata[8:0]);
          pre_nxt  = 4'h0;
        end
        ccp_pkg::off_cmp:  cmp_nxt  = cap_evt ? tmr_r : hwdata[15:0];
        ccp_pkg::off_tmr:  tmr_nxt  = hwdata[15:0];
        ccp_pkg::off_mask: mask_nxt = hwdata[1:0];
        default: ;
      endcase
    end
    // Set beats write-one-to-clear; relies on software clearing after mode change
    st_nxt = st_r | st_set;
    if (wr_en && addr == ccp_pkg::off_status) begin
      st_nxt = (st_r & ~hwdata[1:0]) | st_set;
    end
    irq_nxt = |(st_nxt & mask_nxt);
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (addr)
      ccp_pkg::off_ctrl:   rdata = {23'h00_0000, ctrl_r};
      ccp_pkg::off_cmp:    rdata = {16'h0000, cmp_r};
      ccp_pkg::off_tmr:    rdata = {16'h0000, tmr_r};
      ccp_pkg::off_status: rdata = {30'h0000_0000, st_r};
      ccp_pkg::off_mask:   rdata = {30'h0000_0000, mask_r};
      ccp_pkg::off_pin:    rdata = {29'h0000_0000, cap_lvl, gate_lvl, pin_r};
      default:             rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= ccp_pkg::ctrl_reset;
      cmp_r  <= ccp_pkg::cmp_reset;
      tmr_r  <= ccp_pkg::tmr_reset;
      st_r   <= 2'h0;
      mask_r <= ccp_pkg::mask_reset;
      pin_r  <= 1'b0;
      adc_r  <= 1'b0;
      irq_r  <= 1'b0;
      pre_r  <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cmp_r  <= cmp_nxt;
      tmr_r  <= tmr_nxt;
      st_r   <= st_nxt;
      mask_r <= mask_nxt;
      pin_r  <= pin_nxt;
      adc_r  <= adc_nxt;
      irq_r  <= irq_nxt;
      pre_r  <= pre_nxt;
    end
  end

  assign unit_output_pin = pin_r;
  assign adc_trigger     = adc_r;
  assign irq             = irq_r;

  logic unused;
  assign unused = rd_en ^ ext_lvl ^ hrdata_w;
  assign hrdata_w = 1'b0;

  // ==========================================================================
  // Checks
  chk_gate_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_r.gate_en && gate_lvl != ctrl_r.gate_pol && !wr_en && !match)
      |=> (tmr_r == $past(tmr_r))) else $error("timer moved while gated");
  chk_free_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl_r.gate_en && ctrl_r.tmr_on && !ctrl_r.clk_sel && !sleep && !wr_en && !match)
      |=> (tmr_r == $past(tmr_r) + 16'h0001)) else $error("timer not free running");
  chk_sleep_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep && !ctrl_r.clk_sel && !wr_en) |=> (tmr_r == $past(tmr_r)))
    else $error("timer moved in sleep");
  chk_ext_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_r.clk_sel && !ext_rise && !wr_en) |=> (tmr_r == $past(tmr_r)))
    else $error("timer moved without ext edge");
  chk_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_evt |=> (cmp_r == $past(tmr_r)) && st_r[0]) else $error("capture lost");
  chk_cap_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep && cap_evt) |=> st_r[0]) else $error("capture failed in sleep");
  chk_match_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    match |=> st_r[0] && (adc_r == $past(ctrl_r.adc_en))) else $error("match flag missing");
  chk_match_eq: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_cmp && tick && cmp_r == tmr_r) |=> st_r[0]) else $error("equality missed");
  chk_pin_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (match && ctrl_r.mode == ccp_pkg::mode_set) |=> pin_r) else $error("pin not set");
  chk_tmr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (match && !wr_en && (ctrl_r.mode == ccp_pkg::mode_tgl_clr ||
      ctrl_r.mode == ccp_pkg::mode_pulse_clr)) |=> (tmr_r == 16'h0000))
    else $error("timer not cleared");
endmodule // ccp_timer

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       lvl_r;
  logic       lvl_nxt;

  // ==========================================================================
  // Three stages, change accepted when second and third agree
  always_comb begin
    sh_nxt  = {sh_r[1:0], pin_in};
    lvl_nxt = (sh_r[2] == sh_r[1]) ? sh_r[2] : lvl_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_r  <= 3'h0;
      lvl_r <= 1'b0;
    end else begin
      sh_r  <= sh_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;
  assign rise  = lvl_nxt & ~lvl_r;
  assign fall  = ~lvl_nxt & lvl_r;
endmodule // pin_sync

// ---- testbench/far_end_model.sv ----
`timescale 1ns/1ps
module far_end_model (
  input  wire logic hclk,
  input  wire logic adc_trigger,
  output logic      ext_clk_pin,
  output logic      gate_signal,
  output logic      capture_pin
);
  int adc_seen;
  initial begin
    ext_clk_pin = 1'b0;
    gate_signal = 1'b0;
    capture_pin = 1'b0;
    adc_seen    = 0;
  end
  // ==========================================================================
  // Conversion starts
  always @(posedge hclk) begin
    if (adc_trigger === 1'b1) adc_seen <= adc_seen + 1;
  end
  // ==========================================================================
  // Pins, external clock idle low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge hclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_clk_pin <= 1'b0;
    end
  endtask
  task automatic set_gate(input logic v);
    gate_signal <= v;
  endtask
  task automatic capture_edge(input logic v);
    capture_pin <= v;
  endtask
endmodule // far_end_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, sleep, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, a, b, c;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        ext_clk_pin, gate_signal, capture_pin, unit_output_pin;
  logic        adc_trigger, irq, p, e;
  int          n_fail, total_checks, k;

  ccp_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep(sleep), .ext_clk_pin(ext_clk_pin), .gate_signal(gate_signal),
    .capture_pin(capture_pin), .unit_output_pin(unit_output_pin),
    .adc_trigger(adc_trigger), .irq(irq));
  far_end_model far (.hclk(hclk), .adc_trigger(adc_trigger), .ext_clk_pin(ext_clk_pin),
    .gate_signal(gate_signal), .capture_pin(capture_pin));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================================
  // Helpers
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, ad};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    xfer(ad, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    xfer(ad, 1'b0, 32'h0000_0000, q);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] offs [7];
    offs = '{ccp_pkg::off_ctrl, ccp_pkg::off_cmp, ccp_pkg::off_tmr,
             ccp_pkg::off_status, ccp_pkg::off_mask, ccp_pkg::off_pin, 8'h20};
    wr(8'h20, 32'hFFFF_FFFF);
    foreach (offs[i]) begin
      rd(offs[i], a);
      check("reset value", a, 32'h0000_0000);
    end
    $display("test reset done");
  endtask
  task automatic t_sleep();
    wr(ccp_pkg::off_ctrl, 32'h0000_0100);
    rd(ccp_pkg::off_tmr, a);
    idle(10);
    rd(ccp_pkg::off_tmr, b);
    check("free run", 32'(b != a), 32'h0000_0001);
    sleep <= 1'b1;
    idle(2);
    rd(ccp_pkg::off_tmr, a);
    idle(10);
    rd(ccp_pkg::off_tmr, b);
    check("sleep hold", b, a);
    sleep <= 1'b0;
    idle(10);
    rd(ccp_pkg::off_tmr, c);
    check("wake resume", 32'(c > b && c - b < 64), 32'h0000_0001);
    $display("test sleep done");
  endtask
  task automatic t_gate();
    logic pol, sig, en;
    for (int i = 0; i < 5; i++) begin
      pol = (i == 4) ? 1'b1 : i[1];
      sig = (i == 4) ? 1'b0 : i[0];
      en  = (i != 4);
      far.set_gate(sig);
      wr(ccp_pkg::off_ctrl, 32'h0000_0100 | 32'(en) << 4 | 32'(pol) << 5);
      idle(8);
      rd(ccp_pkg::off_tmr, a);
      idle(10);
      rd(ccp_pkg::off_tmr, b);
      check("gated count", 32'(b != a), 32'(!en || pol == sig));
    end
    $display("test gate done");
  endtask
  task automatic t_compare();
    ccp_pkg::mode_t ms [6];
    ms = '{ccp_pkg::mode_tgl_clr, ccp_pkg::mode_tgl, ccp_pkg::mode_set,
           ccp_pkg::mode_clr, ccp_pkg::mode_pulse, ccp_pkg::mode_pulse_clr};
    foreach (ms[i]) begin
      wr(ccp_pkg::off_ctrl, 32'(ms[i]));
      wr(ccp_pkg::off_tmr, 32'h0000_0000);
      wr(ccp_pkg::off_cmp, 32'h0000_0014);
      wr(ccp_pkg::off_status, 32'h0000_0001);
      wr(ccp_pkg::off_ctrl, 32'h0000_0180 | 32'(ms[i]));
      idle(2);
      p = unit_output_pin;
      k = 0;
      do begin
        @(posedge hclk);
        #1;
        k++;
      end while (adc_trigger !== 1'b1 && k < 100);
      check("adc trigger", 32'(adc_trigger), 32'h0000_0001);
      case (ms[i])
        ccp_pkg::mode_tgl_clr, ccp_pkg::mode_tgl: e = ~p;
        ccp_pkg::mode_clr:                        e = 1'b0;
        default:                                  e = 1'b1;
      endcase
      check("pin action", 32'(unit_output_pin), 32'(e));
      if (ms[i] == ccp_pkg::mode_pulse || ms[i] == ccp_pkg::mode_pulse_clr) begin
        @(posedge hclk);
        #1;
        check("pulse end", 32'(unit_output_pin), 32'h0000_0000);
      end
      @(posedge hclk);
      rd(ccp_pkg::off_status, a);
      check("match flag", a & 32'h0000_0001, 32'h0000_0001);
      rd(ccp_pkg::off_tmr, c);
      e = (ms[i] == ccp_pkg::mode_tgl_clr || ms[i] == ccp_pkg::mode_pulse_clr);
      check("timer clear", 32'(c < 20), 32'(e));
    end
    check("adc seen", 32'(far.adc_seen != 0), 32'h0000_0001);
    wr(ccp_pkg::off_mask, 32'h0000_0000);
    idle(2);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(ccp_pkg::off_mask, 32'h0000_0001);
    idle(2);
    check("irq raised", 32'(irq), 32'h0000_0001);
    wr(ccp_pkg::off_ctrl, 32'h0000_0000);
    wr(ccp_pkg::off_status, 32'h0000_0001);
    idle(2);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    $display("test compare done");
  endtask
  task automatic t_capture();
    wr(ccp_pkg::off_mask, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      wr(ccp_pkg::off_ctrl, i == 0 ? 32'h0000_0005 : 32'h0000_0004);
      wr(ccp_pkg::off_tmr, i == 0 ? 32'h0000_1234 : 32'h0000_0ABC);
      idle(8);
      wr(ccp_pkg::off_status, 32'h0000_0001);
      far.capture_edge(i == 0);
      idle(8);
      rd(ccp_pkg::off_cmp, a);
      check("capture value", a, i == 0 ? 32'h0000_1234 : 32'h0000_0ABC);
      rd(ccp_pkg::off_status, b);
      check("capture flag", b & 32'h0000_0001, 32'h0000_0001);
    end
    wr(ccp_pkg::off_tmr, 32'h0000_0000);
    wr(ccp_pkg::off_ctrl, 32'h0000_0145);
    sleep <= 1'b1;
    wr(ccp_pkg::off_status, 32'h0000_0001);
    far.ext_pulses(5);
    idle(8);
    far.capture_edge(1'b1);
    idle(8);
    rd(ccp_pkg::off_cmp, a);
    check("sleep capture", a, 32'h0000_0005);
    rd(ccp_pkg::off_status, b);
    check("sleep flag", b & 32'h0000_0001, 32'h0000_0001);
    sleep <= 1'b0;
    far.capture_edge(1'b0);
    wr(ccp_pkg::off_ctrl, 32'h0000_0006);
    wr(ccp_pkg::off_tmr, 32'h0000_0777);
    idle(8);
    wr(ccp_pkg::off_status, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      rd(ccp_pkg::off_status, b);
      check("every fourth", b & 32'h0000_0001, 32'h0000_0000);
      far.capture_edge(1'b1);
      idle(8);
      far.capture_edge(1'b0);
      idle(8);
    end
    rd(ccp_pkg::off_cmp, a);
    check("fourth capture", a, 32'h0000_0777);
    $display("test capture done");
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    n_fail = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    sleep = 1'b0;
    idle(20);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_sleep();
    t_gate();
    t_compare();
    t_capture();
    conclude();
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule // tb
